// >>> verilog/lvdm_defines.svh
// constants for the low-voltage detect monitor
`ifndef LVDM_DEFINES_SVH
`define LVDM_DEFINES_SVH
// register byte offsets
`define LVDM_OFF_CTRL     8'h00
`define LVDM_OFF_STATUS   8'h04
`define LVDM_OFF_CLEAR    8'h08
`define LVDM_OFF_IRQ_EN   8'h0C
`define LVDM_OFF_LEVEL    8'h10
// control fields
`define LVDM_CTRL_SEL_LO  0
`define LVDM_CTRL_SEL_HI  1
`define LVDM_CTRL_ENABLE  3
`define LVDM_CTRL_RESET   8'h00
// status / enable fields
`define LVDM_ST_FLAG      0
`define LVDM_ST_HALT      1
`define LVDM_ST_RESET     2
// level register fields
`define LVDM_LV_BELOW_DET 0
`define LVDM_LV_BELOW_RST 1
`define LVDM_LV_HALTED    2
`define LVDM_LV_SLEEP     3
// dip timing
`define LVDM_DIP_NS       80000
`define LVDM_CLK_NS       10
`define LVDM_DIP_CYC      (`LVDM_DIP_NS / `LVDM_CLK_NS)
// axi responses
`define LVDM_RESP_OKAY    2'h0
`define LVDM_RESP_SLVERR  2'h2
`endif

// >>> verilog/lvdm_pkg.sv
// types for the low-voltage detect monitor
package lvdm_pkg;
   // threshold select codes
   typedef enum logic [1:0] {
      LVDM_TH_2V2 = 2'h0,
      LVDM_TH_3V3 = 2'h1,
      LVDM_TH_4V0 = 2'h2,
      LVDM_TH_4V5 = 2'h3
   } lvdm_thresh_t;
   // supply monitor states
   typedef enum logic [1:0] {
      LVDM_ST_OK    = 2'h0,
      LVDM_ST_DIP   = 2'h1,
      LVDM_ST_RESET = 2'h2
   } lvdm_state_t;
   // analog comparator bundle, one bit per threshold
   typedef struct packed {
      logic [3:0] below_det;
      logic       below_rst;
   } lvdm_analog_t;
endpackage

// >>> verilog/lvdm_monitor.sv
// low-voltage detect and brown-out monitor with axi4-lite registers
//
// Contract
// R1: software enables detector, then programs threshold; here CTRL takes enable and select in one write
// R2: software enables irq, waits, clears flag
// R3: detector keeps working during sleep
// R4: flag set in sleep does not wake
// R5: flag stays pending through sleep
// R6: any system reset clears the flag
// R7: supply above threshold keeps flag zero
// R8: supply below threshold sets flag to one
// R9: flag sticky, only software write clears
// R10: short reset-level dip halts, keeps state
// R11: dip beyond 80us forces system reset
// R12: select code picks one of four levels
// R13: irq enable gates request, not flag
// R14: comparators synchronised, counter times dip
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "lvdm_defines.svh"
module lvdm_monitor #(
   parameter int DIP_CYCLES = `LVDM_DIP_CYC
) (
   // clock, reset, enable
   input  wire logic                core_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                clk_en_in,
   // analog comparators and core state
   input  wire lvdm_pkg::lvdm_analog_t analog_in,
   input  wire logic                sleep_in,
   input  wire logic                global_irq_enable_instr_in,
   // axi4-lite write address
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // axi4-lite write response
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   // axi4-lite read address
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   // axi4-lite read data
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // outputs to the core
   output logic                     irq_out,
   output logic                     lowvolt_vector_out,
   output logic                     core_halt_out,
   output logic                     sys_reset_req_out
);
   // released reset copy
   logic                rst_sync1_reg;
   logic                rst_n;
   // synchroniser stages
   logic [4:0]          ana_meta_reg;
   logic [4:0]          ana_sync_reg;
   // control bits
   logic                detector_enable_reg;
   logic                threshold_sel_hi_reg;
   logic                threshold_sel_lo_reg;
   // sticky status and enables
   logic [2:0]          status_reg;
   logic [2:0]          irq_en_reg;
   // dip monitor
   lvdm_pkg::lvdm_state_t state_reg;
   logic [31:0]         dip_cnt_reg;
   // bus handshake state
   logic                aw_held_reg;
   logic                w_held_reg;
   logic [7:0]          aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;
   // derived
   logic                below_det;
   logic                below_rst;
   logic                wr_fire;
   logic [2:0]          ev_set;
   logic [2:0]          ev_clr;
   logic                dip_long;

   // reset release through two flops; async assert only
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync1_reg <= 1'b0;
         rst_n         <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n         <= rst_sync1_reg;
      end
   end

   // pick the comparator for the selected level
   function automatic logic sel_cmp(input logic [3:0] cmp,
                                    input logic [1:0] code);
      unique case (lvdm_pkg::lvdm_thresh_t'(code))
         lvdm_pkg::LVDM_TH_2V2: sel_cmp = cmp[0]; // R12
         lvdm_pkg::LVDM_TH_3V3: sel_cmp = cmp[1];
         lvdm_pkg::LVDM_TH_4V0: sel_cmp = cmp[2];
         lvdm_pkg::LVDM_TH_4V5: sel_cmp = cmp[3];
      endcase
   endfunction

   // address match helper, used by both bus channels
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction

   // two-flop synchroniser; runs regardless of sleep
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ana_meta_reg <= 5'h00;
         ana_sync_reg <= 5'h00;
      end else if (clk_en_in) begin
         ana_meta_reg <= analog_in;              // R14
         ana_sync_reg <= ana_meta_reg;           // R3
      end
   end

   assign below_det = detector_enable_reg & sel_cmp(ana_sync_reg[4:1],
                      {threshold_sel_hi_reg, threshold_sel_lo_reg});
   assign below_rst = ana_sync_reg[0];
   assign dip_long  = (dip_cnt_reg >= 32'(DIP_CYCLES));

   // brown-out dip timer: halt first, reset if it lasts
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= lvdm_pkg::LVDM_ST_OK;
         dip_cnt_reg <= 32'h00000000;
      end else if (clk_en_in) begin
         unique case (state_reg)
            lvdm_pkg::LVDM_ST_OK: begin
               dip_cnt_reg <= 32'h00000000;
               if (below_rst) begin
                  state_reg <= lvdm_pkg::LVDM_ST_DIP; // R10
               end
            end
            lvdm_pkg::LVDM_ST_DIP: begin
               if (!below_rst) begin
                  state_reg <= lvdm_pkg::LVDM_ST_OK;  // short dip ends
               end else if (dip_long) begin
                  state_reg <= lvdm_pkg::LVDM_ST_RESET; // R11
               end else begin
                  dip_cnt_reg <= dip_cnt_reg + 32'h00000001; // R14
               end
            end
            lvdm_pkg::LVDM_ST_RESET: begin
               // held until the supply rises back above the reset level
               if (!below_rst) begin
                  state_reg <= lvdm_pkg::LVDM_ST_OK;
               end
            end
            default: state_reg <= lvdm_pkg::LVDM_ST_OK;
         endcase
      end
   end

   assign core_halt_out     = (state_reg == lvdm_pkg::LVDM_ST_DIP); // R10
   assign sys_reset_req_out = (state_reg == lvdm_pkg::LVDM_ST_RESET); // R11

   // status events
   assign ev_set = {sys_reset_req_out, core_halt_out, below_det};
   assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign ev_clr = (wr_fire && hit(aw_addr_reg, `LVDM_OFF_CLEAR)
                    && w_strb_reg[0]) ? w_data_reg[2:0] : 3'h0;

   // sticky status: set wins over clear, never cleared by recovery
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= 3'h0;                     // R6
      end else if (clk_en_in) begin
         // R7 R8 R9
         status_reg <= (status_reg & ~ev_clr) | ev_set;
      end
   end

   // interrupt request only from enabled bits; no wake path exists
   assign irq_out = |(status_reg & irq_en_reg); // R13 R4 R5
   assign lowvolt_vector_out = global_irq_enable_instr_in & ~sleep_in &
      status_reg[`LVDM_ST_FLAG] & irq_en_reg[`LVDM_ST_FLAG]; // R8 R5

   // write channel capture; address and data in either order
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LVDM_RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            // status and level are read-only: error on write
            s_axi_bresp  <= (hit(aw_addr_reg, `LVDM_OFF_CTRL) ||
                             hit(aw_addr_reg, `LVDM_OFF_CLEAR) ||
                             hit(aw_addr_reg, `LVDM_OFF_IRQ_EN)) ?
                            `LVDM_RESP_OKAY : `LVDM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // readies drop while frozen, so no beat is offered that nobody captures
   assign s_axi_awready = clk_en_in & ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = clk_en_in & ~w_held_reg & ~s_axi_bvalid;

   // software-written control and enables
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         detector_enable_reg  <= 1'b0;
         threshold_sel_hi_reg <= 1'b0;
         threshold_sel_lo_reg <= 1'b0;
         irq_en_reg           <= 3'h0;
      end else if (clk_en_in && wr_fire && w_strb_reg[0]) begin
         if (hit(aw_addr_reg, `LVDM_OFF_CTRL)) begin
            // enable and level select are both taken from the same CTRL write
            detector_enable_reg  <= w_data_reg[`LVDM_CTRL_ENABLE]; // R1
            threshold_sel_hi_reg <= w_data_reg[`LVDM_CTRL_SEL_HI];
            threshold_sel_lo_reg <= w_data_reg[`LVDM_CTRL_SEL_LO];
         end
         if (hit(aw_addr_reg, `LVDM_OFF_IRQ_EN)) begin
            irq_en_reg <= w_data_reg[2:0]; // R2
         end
      end
   end

   // read channel: one-cycle latency, held until taken
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `LVDM_RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `LVDM_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            if (hit(s_axi_araddr, `LVDM_OFF_CTRL)) begin
               s_axi_rdata[`LVDM_CTRL_ENABLE] <= detector_enable_reg;
               s_axi_rdata[`LVDM_CTRL_SEL_HI] <= threshold_sel_hi_reg;
               s_axi_rdata[`LVDM_CTRL_SEL_LO] <= threshold_sel_lo_reg;
            end else if (hit(s_axi_araddr, `LVDM_OFF_STATUS)) begin
               s_axi_rdata[2:0] <= status_reg;
            end else if (hit(s_axi_araddr, `LVDM_OFF_IRQ_EN)) begin
               s_axi_rdata[2:0] <= irq_en_reg;
            end else if (hit(s_axi_araddr, `LVDM_OFF_LEVEL)) begin
               s_axi_rdata[`LVDM_LV_BELOW_DET] <= below_det;
               s_axi_rdata[`LVDM_LV_BELOW_RST] <= below_rst;
               s_axi_rdata[`LVDM_LV_HALTED]    <= core_halt_out;
               s_axi_rdata[`LVDM_LV_SLEEP]     <= sleep_in;
            end else if (!hit(s_axi_araddr, `LVDM_OFF_CLEAR)) begin
               s_axi_rresp <= `LVDM_RESP_SLVERR; // unmapped
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign s_axi_arready = clk_en_in & ~s_axi_rvalid;

   // checks
   property p_flag_set;
      @(posedge core_clk_in) disable iff (!rst_n)
      (clk_en_in && below_det) |=> status_reg[`LVDM_ST_FLAG];
   endproperty
   a_flag_set: assert property (p_flag_set) // R8
      else $error("flag not set below threshold");

   property p_flag_sticky;
      @(posedge core_clk_in) disable iff (!rst_n)
      (status_reg[0] && !ev_clr[0]) |=> status_reg[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // R9
      else $error("flag dropped without software clear");

   property p_flag_quiet;
      @(posedge core_clk_in) disable iff (!rst_n)
      (!status_reg[0] && !below_det) |=> !status_reg[0];
   endproperty
   a_flag_quiet: assert property (p_flag_quiet) // R7
      else $error("flag rose above threshold");

   property p_irq_gate;
      @(posedge core_clk_in) disable iff (!rst_n)
      (!irq_en_reg[0] && !irq_en_reg[1] && !irq_en_reg[2]) |-> !irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate) // R13
      else $error("irq while all enables off");

   property p_no_wake;
      @(posedge core_clk_in) disable iff (!rst_n)
      sleep_in |-> !lowvolt_vector_out;
   endproperty
   a_no_wake: assert property (p_no_wake) // R4
      else $error("vector taken during sleep");

   property p_short_halt;
      @(posedge core_clk_in) disable iff (!rst_n)
      (clk_en_in && state_reg == lvdm_pkg::LVDM_ST_OK && below_rst)
         |=> core_halt_out && !sys_reset_req_out;
   endproperty
   a_short_halt: assert property (p_short_halt) // R10
      else $error("dip did not halt");

   property p_long_reset;
      @(posedge core_clk_in) disable iff (!rst_n)
      (clk_en_in && core_halt_out && below_rst && dip_long)
         |=> sys_reset_req_out;
   endproperty
   a_long_reset: assert property (p_long_reset) // R11
      else $error("long dip gave no reset");

   property p_early_no_reset;
      @(posedge core_clk_in) disable iff (!rst_n)
      (core_halt_out && !dip_long) |=> !sys_reset_req_out;
   endproperty
   a_early_no_reset: assert property (p_early_no_reset) // R14
      else $error("reset before dip time");

   property p_reset_clear;
      @(posedge core_clk_in) $rose(rst_n) |-> !status_reg[0];
   endproperty
   a_reset_clear: assert property (p_reset_clear) // R6
      else $error("flag survived reset");
endmodule

// >>> sim/test_lvdm_monitor.sv
// self-checking bench for the low-voltage detect monitor
`timescale 1ns/100ps
`include "lvdm_defines.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   err_total++; $display("wrong value %s exp %0h got %0h", nm, ex, got); \
   end end
module test_lvdm_monitor;
   // short dip limit keeps the run brief
   localparam int DIP = 20;
   logic                   clk = 1'b0;   // system clock
   logic                   rst_n = 1'b0; // async reset, active low
   lvdm_pkg::lvdm_analog_t an = '0;      // comparator levels
   logic                   slp = 1'b0;   // core asleep
   logic                   gie = 1'b0;   // global irq enable
   logic                   ce = 1'b1;    // clock enable
   // bus master side
   logic                   awv = 1'b0;
   logic                   wv = 1'b0;
   logic                   bry = 1'b0;
   logic                   arv = 1'b0;
   logic                   rry = 1'b0;
   logic [7:0]             awa = 8'h00;
   logic [7:0]             ara = 8'h00;
   logic [31:0]            wd = 32'h0;
   // design answers
   logic                   awr, wrd, bv, arr, rv;
   logic [1:0]             brsp, rrsp;
   logic [31:0]            rdat;
   logic                   irq, vec, halt, sreq;
   // scratch and tallies
   logic [31:0]            d;
   logic [1:0]             r;
   int                     err_total = 0;
   int                     checks_done = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   lvdm_monitor #(.DIP_CYCLES(DIP)) lvdm_monitor_inst (
      .core_clk_in                (clk),
      .rst_n_in                   (rst_n),
      .clk_en_in                  (ce),
      .analog_in                  (an),
      .sleep_in                   (slp),
      .global_irq_enable_instr_in (gie),
      .s_axi_awvalid              (awv),
      .s_axi_awready              (awr),
      .s_axi_awaddr               (awa),
      .s_axi_wvalid               (wv),
      .s_axi_wready               (wrd),
      .s_axi_wdata                (wd),
      .s_axi_wstrb                (4'hF),
      .s_axi_bvalid               (bv),
      .s_axi_bready               (bry),
      .s_axi_bresp                (brsp),
      .s_axi_arvalid              (arv),
      .s_axi_arready              (arr),
      .s_axi_araddr               (ara),
      .s_axi_rvalid               (rv),
      .s_axi_rready               (rry),
      .s_axi_rdata                (rdat),
      .s_axi_rresp                (rrsp),
      .irq_out                    (irq),
      .lowvolt_vector_out         (vec),
      .core_halt_out              (halt),
      .sys_reset_req_out          (sreq)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // write: readies judged at negedge, transfer happens at next posedge
   task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                     output logic [1:0] rs);
      logic ta;
      logic tw;
      begin
         @(posedge clk);
         awa <= a;
         wd <= dv;
         awv <= 1'b1;
         wv <= 1'b1;
         bry <= 1'b1;
         ta = 1'b0;
         tw = 1'b0;
         while (!(ta && tw)) begin
            @(negedge clk);
            if (awv && awr) ta = 1'b1;
            if (wv && wrd) tw = 1'b1;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
         end
         // response may already stand; wait is cut by the watchdog
         while (!bv) @(negedge clk);
         rs = brsp;
         @(posedge clk);
         bry <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                     output logic [1:0] rs);
      logic tk;
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'b1;
         rry <= 1'b1;
         tk = 1'b0;
         while (!tk) begin
            @(negedge clk);
            tk = arr;
            @(posedge clk);
         end
         arv <= 1'b0;
         do @(negedge clk); while (!rv);
         dv = rdat;
         rs = rrsp;
         @(posedge clk);
         rry <= 1'b0;
      end
   endtask

   // write expecting an okay answer
   task automatic wo(input logic [7:0] a, input logic [31:0] dv);
      logic [1:0] rs;
      begin
         wr(a, dv, rs);
         `CHK("write resp", `LVDM_RESP_OKAY, rs)
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] ex);
      logic [31:0] dv;
      logic [1:0]  rs;
      begin
         rd(a, dv, rs);
         `CHK(nm, ex, dv)
      end
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog: the tests need well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      rchk("ctrl", `LVDM_OFF_CTRL, 32'h0);
      rchk("status", `LVDM_OFF_STATUS, 32'h0);
      rchk("irq_en", `LVDM_OFF_IRQ_EN, 32'h0);
      // detector still off: a low supply leaves no trace
      an.below_det <= 4'hF;
      cyc(6);
      rchk("flag off", `LVDM_OFF_STATUS, 32'h0);
      an.below_det <= 4'h0;
      done("reset");
      // each select code: just above, then just below its level
      for (int i = 0; i < 4; i++) begin
         wo(`LVDM_OFF_CTRL, 32'h8 | i);
         an.below_det <= 4'(4'hE << i);
         cyc(6);
         rchk("flag above", `LVDM_OFF_STATUS, 32'h0);
         an.below_det <= 4'(4'hF << i);
         cyc(6);
         rchk("flag below", `LVDM_OFF_STATUS, 32'h1);
         an.below_det <= 4'h0;
         cyc(6);
         rchk("flag held", `LVDM_OFF_STATUS, 32'h1);
         wo(`LVDM_OFF_CLEAR, 32'h1);
         rchk("flag cleared", `LVDM_OFF_STATUS, 32'h0);
      end
      done("thresholds");
      // frozen clock enable: a low supply is never sampled
      ce <= 1'b0;
      an.below_det <= 4'hF;
      cyc(6);
      an.below_det <= 4'h0;
      cyc(1);
      ce <= 1'b1;
      cyc(6);
      rchk("frozen", `LVDM_OFF_STATUS, 32'h0);
      done("clock enable");
      // enable gates the request, never the flag
      gie <= 1'b1;
      an.below_det <= 4'hF;
      cyc(6);
      @(negedge clk);
      `CHK("irq masked", 1'b0, irq)
      `CHK("vec masked", 1'b0, vec)
      wo(`LVDM_OFF_IRQ_EN, 32'h1);
      @(negedge clk);
      `CHK("irq", 1'b1, irq)
      `CHK("vector", 1'b1, vec)
      cyc(1);
      an.below_det <= 4'h0;
      cyc(6);
      wo(`LVDM_OFF_CLEAR, 32'h1);
      @(negedge clk);
      `CHK("irq cleared", 1'b0, irq)
      done("interrupt");
      // drop while asleep: recorded, no wake, pending afterwards
      cyc(1);
      slp <= 1'b1;
      an.below_det <= 4'hF;
      cyc(6);
      @(negedge clk);
      `CHK("irq asleep", 1'b1, irq)
      `CHK("vector asleep", 1'b0, vec)
      cyc(1);
      slp <= 1'b0;
      an.below_det <= 4'h0;
      cyc(1);
      @(negedge clk);
      `CHK("vector awake", 1'b1, vec)
      rchk("flag pending", `LVDM_OFF_STATUS, 32'h1);
      cyc(6);
      wo(`LVDM_OFF_CLEAR, 32'h1);
      done("sleep");
      // short dip halts and keeps state
      an <= '{below_det: 4'hF, below_rst: 1'b1};
      cyc(10);
      @(negedge clk);
      `CHK("halt", 1'b1, halt)
      `CHK("no reset", 1'b0, sreq)
      rchk("level", `LVDM_OFF_LEVEL, 32'h7);
      cyc(1);
      an <= '0;
      cyc(6);
      @(negedge clk);
      `CHK("resumed", 1'b0, halt)
      rchk("dip seen", `LVDM_OFF_STATUS, 32'h3);
      rchk("ctrl kept", `LVDM_OFF_CTRL, 32'hB);
      wo(`LVDM_OFF_CLEAR, 32'h7);
      // long dip: counter runs out, reset requested
      an <= '{below_det: 4'hF, below_rst: 1'b1};
      cyc(15);
      @(negedge clk);
      `CHK("halt long", 1'b1, halt)
      `CHK("reset early", 1'b0, sreq)
      cyc(15);
      @(negedge clk);
      `CHK("reset req", 1'b1, sreq)
      cyc(1);
      an <= '0;
      cyc(6);
      rchk("long dip seen", `LVDM_OFF_STATUS, 32'h7);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      rchk("flag after reset", `LVDM_OFF_STATUS, 32'h0);
      rchk("ctrl after reset", `LVDM_OFF_CTRL, 32'h0);
      done("dips");
      // refusals: unmapped read, write to a read-only place
      rd(8'h14, d, r);
      `CHK("unmapped resp", `LVDM_RESP_SLVERR, r)
      `CHK("unmapped data", 32'h0, d)
      wr(`LVDM_OFF_STATUS, 32'h1, r);
      `CHK("ro resp", `LVDM_RESP_SLVERR, r)
      done("bus errors");
      tally_and_finish();
   end
endmodule
